// [hw/uhc_checker.sv]
// Function
// - word at byte 0 is the header format version
// - update revision compared as signed 32-bit value
// - revision at byte 4 is reported as the active update signature
// - word at byte 8 holds creation date mmddyyyy
// - word at byte 12 must equal processor identification query value exactly
// - 32-bit sum of all image words must be zero; checksum at 16
// - word at byte 20 is required loader version; first is one
// - low 8 bits at byte 24 must share a set bit with platform id
// - payload length at 28, word multiple, zero means 2000; starts at 48
// - word at byte 32 is total image length in bytes
// - header bytes 36 to 47 are reserved and ignored
// - word after payload gives extended entry count
// - extended table words must sum to zero; checksum at payload plus 52
// - entry n signature at payload plus 68 plus 12n
// - entry n flags at payload plus 72 plus 12n, matched like primary
// - header is exactly 48 bytes, version governs other fields; version is only captured, never checked
// - extended table length is total minus payload minus 48
// - refuse image whose signature matches no processor signature
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
module uhc_checker (
  input  wire logic                        core_clk_in,
  input  wire logic                        reset_in,
  input  wire logic [5:0]                  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [31:0]                 avs_writedata_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  output logic      [31:0]                 avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic [uhc_pkg::WORD_W-1:0]  img_data_in,
  input  wire logic                        img_valid_in,
  output logic                             img_ready_out,
  output logic                             done_out,
  output logic                             reject_out
);
  import uhc_pkg::*;

  uhc_state_type state;
  logic [31:0] proc_sig;
  logic [7:0]  plat_id;
  logic [31:0] loader_ver;
  logic [31:0] hdr_version;
  logic [31:0] upd_revision;
  logic [31:0] date_word;
  logic [31:0] img_sig;
  logic [31:0] img_checksum;
  logic [31:0] loader_rev;
  logic [31:0] plat_flags;
  logic [31:0] data_size;
  logic [31:0] total_size;
  logic [31:0] ext_count;
  logic [31:0] active_rev;
  logic [31:0] byte_off;
  logic [31:0] sum_all;
  logic [31:0] sum_ext;
  logic [31:0] entry_off;
  logic [31:0] ent_num;
  logic        sig_hit;
  logic        plat_hit;
  logic [5:0]  cause;
  logic [5:0]  next_cause;
  logic        rd_ack;
  logic [31:0] next_readdata;

  // payload length with the zero default applied
  function automatic logic [31:0] eff_len(input logic [31:0] size);
    eff_len = (size == RESET_ZERO) ? DEFAULT_DATA : size;
  endfunction : eff_len

  // platform flag match shared by primary and extended entries
  function automatic logic plat_match(input logic [31:0] flags, input logic [7:0] id);
    plat_match = |(flags[PLAT_BITS-1:0] & id);
  endfunction : plat_match

  // true when the offered word is header word idx
  function automatic logic at_hdr_word(input logic [31:0] off, input logic [31:0] idx);
    at_hdr_word = (off < HDR_BYTES) && (off[31:2] == idx[29:0]);
  endfunction : at_hdr_word

  // word address to byte address, shared by write and read decode
  function automatic logic [7:0] reg_byte(input logic [5:0] addr);
    reg_byte = {addr, 2'b00};
  endfunction : reg_byte

  // status layout: flags low, cause bits from bit 8 up
  function automatic logic [31:0] status_word(input logic done, input logic rej,
                                              input logic busy, input logic [5:0] c);
    status_word                = RESET_ZERO;
    status_word[ST_DONE]       = done;
    status_word[ST_REJECT]     = rej;
    status_word[ST_BUSY]       = busy;
    status_word[ST_C_CSUM]     = c[0];
    status_word[ST_C_EXT_CSUM] = c[1];
    status_word[ST_C_SIZE]     = c[2];
    status_word[ST_C_SIG]      = c[3];
    status_word[ST_C_PLAT]     = c[4];
    status_word[ST_C_LOADER]   = c[5];
  endfunction : status_word

  wire logic [31:0] pay_len  = eff_len(data_size);
  wire logic [31:0] ext_base = pay_len + HDR_BYTES;
  wire logic [31:0] img_end  = (data_size == RESET_ZERO) ?
                               (HDR_BYTES + DEFAULT_DATA) : total_size;
  wire logic        take     = img_valid_in && img_ready_out;
  wire logic [31:0] word_idx = {2'b00, byte_off[31:2]};
  wire logic [31:0] sum_next = sum_all + img_data_in;
  // never ends inside the header, so size fields left from an earlier image
  // cannot cut the scan short; an image shorter than the header stalls
  wire logic        last_w   = ((byte_off + 32'h0000_0004) >= img_end) &&
                               ((byte_off + 32'h0000_0004) >= HDR_BYTES);
  wire logic        in_ext   = (data_size != RESET_ZERO) && (byte_off >= ext_base);
  wire logic        has_ext  = (data_size != RESET_ZERO) && (total_size > ext_base);
  // table sum takes only words past the payload
  wire logic [31:0] next_sum_ext = in_ext ? (sum_ext + img_data_in) : sum_ext;
  // address decode
  wire logic [7:0]  reg_addr = reg_byte(avs_address_in);
  wire logic        wr_ctrl  = avs_write_in && avs_byteenable_in[0] && (reg_addr == REG_CTRL);
  wire logic        start    = wr_ctrl && avs_writedata_in[CTRL_START] && (state != UHC_SCAN);
  // extended table position
  wire logic        ext_body = in_ext && (byte_off >= ext_base + EXT_HDR_BYTES);
  wire logic        ent_idx_ok = ent_num < ext_count;
  // current word as a matching field; shared by hit flags and verdict
  wire logic        hdr_sig_now  = at_hdr_word(byte_off, IDX_PROC_SIG) &&
                                   (img_data_in == proc_sig);
  wire logic        hdr_plat_now = at_hdr_word(byte_off, IDX_PLAT_FLAGS) &&
                                   plat_match(img_data_in, plat_id);
  wire logic        ext_sig_now  = ext_body && ent_idx_ok && (entry_off == SIG_IN_ENTRY) &&
                                   (img_data_in == proc_sig);
  wire logic        ext_plat_now = ext_body && ent_idx_ok && (entry_off == FLAGS_IN_ENTRY) &&
                                   plat_match(img_data_in, plat_id);
  // size sanity: payload word multiple, payload fits in total, total word multiple
  wire logic        size_frac  = (data_size[1:0] != 2'b00);
  wire logic        size_short = (data_size != RESET_ZERO) && (total_size < ext_base);
  wire logic        size_odd   = (total_size[1:0] != 2'b00);
  // loader must be at least the first and no newer than the one supported
  wire logic        ldr_bad    = ($signed(loader_rev) > $signed(loader_ver)) ||
                                 (loader_rev < FIRST_LOADER_REV);

  // relied on: words arrive in ascending order, one per handshake
  assign img_ready_out = (state == UHC_SCAN);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state <= UHC_IDLE;
    end else begin
      case (state)
        UHC_IDLE: begin
          if (start) begin
            state <= UHC_SCAN;
          end
        end
        UHC_SCAN: begin
          if (take && last_w) begin
            state <= UHC_DONE;
          end
        end
        UHC_DONE: begin
          if (start) begin
            state <= UHC_SCAN;
          end
        end
        default: state <= UHC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      byte_off <= RESET_ZERO;
      sum_all  <= RESET_ZERO;
      sum_ext  <= RESET_ZERO;
    end else if (start) begin
      byte_off <= RESET_ZERO;
      sum_all  <= RESET_ZERO;
      sum_ext  <= RESET_ZERO;
    end else if (take) begin
      byte_off <= byte_off + 32'h0000_0004;
      sum_all  <= sum_next;
      sum_ext  <= next_sum_ext;
    end
  end

  // header capture; reserved bytes 36..47 fall through untouched
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      hdr_version  <= RESET_ZERO;
      upd_revision <= RESET_ZERO;
      date_word    <= RESET_ZERO;
      img_sig      <= RESET_ZERO;
      img_checksum <= RESET_ZERO;
      loader_rev   <= RESET_ZERO;
      plat_flags   <= RESET_ZERO;
      data_size    <= RESET_ZERO;
      total_size   <= RESET_ZERO;
    end else if (take && (byte_off < HDR_BYTES)) begin
      case (word_idx)
        IDX_HDR_VERSION:  hdr_version  <= img_data_in;
        IDX_UPD_REVISION: upd_revision <= img_data_in;
        IDX_DATE:         date_word    <= img_data_in;
        IDX_PROC_SIG:     img_sig      <= img_data_in;
        IDX_CHECKSUM:     img_checksum <= img_data_in;
        IDX_LOADER_REV:   loader_rev   <= img_data_in;
        IDX_PLAT_FLAGS:   plat_flags   <= img_data_in;
        IDX_DATA_SIZE:    data_size    <= img_data_in;
        IDX_TOTAL_SIZE:   total_size   <= img_data_in;
        default: ;
      endcase
    end
  end

  // extended table walk
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ext_count <= RESET_ZERO;
      entry_off <= RESET_ZERO;
      ent_num   <= RESET_ZERO;
    end else if (start) begin
      ext_count <= RESET_ZERO;
      entry_off <= RESET_ZERO;
      ent_num   <= RESET_ZERO;
    end else if (take && in_ext) begin
      if (byte_off == ext_base) ext_count <= img_data_in;
      if (ext_body) begin
        // stride of 12 bytes per entry; counting avoids a divider
        if (entry_off == EXT_ENTRY_BYTES - 32'h0000_0004) begin
          entry_off <= RESET_ZERO;
          ent_num   <= ent_num + 32'h0000_0001;
        end else begin
          entry_off <= entry_off + 32'h0000_0004;
        end
      end
    end
  end

  // a match in any entry wins; only entries within the declared count count
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sig_hit  <= 1'b0;
      plat_hit <= 1'b0;
    end else if (start) begin
      sig_hit  <= 1'b0;
      plat_hit <= 1'b0;
    end else if (take) begin
      if (hdr_sig_now)
        sig_hit <= 1'b1;
      if (hdr_plat_now)
        plat_hit <= 1'b1;
      if (ext_sig_now)
        sig_hit <= 1'b1;
      if (ext_plat_now)
        plat_hit <= 1'b1;
    end
  end

  // verdict at last word; causes stay until next start
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cause <= 6'h00;
    end else if (start) begin
      cause <= 6'h00;
    end else if (take && last_w) begin
      cause <= next_cause;
    end
  end

  // verdict for the word now offered, latched only on the last one
  always_comb begin
    next_cause    = 6'h00;
    next_cause[0] = (sum_next != RESET_ZERO);
    next_cause[1] = has_ext && (next_sum_ext != RESET_ZERO);
    next_cause[2] = size_frac || size_short || size_odd;
    next_cause[3] = !(sig_hit || hdr_sig_now || ext_sig_now);
    next_cause[4] = !(plat_hit || hdr_plat_now || ext_plat_now);
    next_cause[5] = ldr_bad;
  end

  // accepted revision becomes the reported active signature only if signed greater than it
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      active_rev <= RESET_ZERO;
    end else if (state == UHC_DONE && !reject_out && active_rev != upd_revision &&
                 $signed(upd_revision) > $signed(active_rev)) begin
      active_rev <= upd_revision;
    end
  end

  assign done_out   = (state == UHC_DONE);
  assign reject_out = (state == UHC_DONE) && (|cause);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      proc_sig   <= RESET_ZERO;
      plat_id    <= 8'h00;
      loader_ver <= FIRST_LOADER_REV;
    end else if (avs_write_in && (state != UHC_SCAN)) begin
      // config locked during a scan so the verdict stays coherent
      case (reg_addr)
        REG_PROC_SIG:   proc_sig   <= avs_writedata_in;
        REG_PLAT_ID:    plat_id    <= avs_writedata_in[7:0];
        REG_LOADER_VER: loader_ver <= avs_writedata_in;
        default: ;
      endcase
    end
  end

  always_comb begin
    next_readdata = RESET_ZERO;
    case (reg_addr)
      REG_STATUS:       next_readdata = status_word(done_out, reject_out,
                                                    (state == UHC_SCAN), cause);
      REG_PROC_SIG:     next_readdata = proc_sig;
      REG_PLAT_ID:      next_readdata = {24'h00_0000, plat_id};
      REG_LOADER_VER:   next_readdata = loader_ver;
      REG_HDR_VERSION:  next_readdata = hdr_version;
      REG_UPD_REVISION: next_readdata = upd_revision;
      REG_DATE:         next_readdata = date_word;
      REG_IMG_SIG:      next_readdata = img_sig;
      REG_IMG_CHECKSUM: next_readdata = img_checksum;
      REG_LOADER_REV:   next_readdata = loader_rev;
      REG_PLAT_FLAGS:   next_readdata = plat_flags;
      REG_DATA_SIZE:    next_readdata = data_size;
      REG_TOTAL_SIZE:   next_readdata = total_size;
      REG_EXT_COUNT:    next_readdata = ext_count;
      REG_NEWER:        next_readdata = active_rev;
      default:          next_readdata = RESET_ZERO;
    endcase
  end

  // reads take one wait cycle so data comes from a flop
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_ack           <= 1'b0;
      avs_readdata_out <= RESET_ZERO;
    end else begin
      rd_ack           <= avs_read_in && !rd_ack;
      avs_readdata_out <= next_readdata;
    end
  end

  assign avs_waitrequest_out = avs_read_in && !rd_ack;
endmodule : uhc_checker

// [hw/uhc_pkg.sv]
package uhc_pkg;
  localparam int unsigned WORD_W           = 32;
  localparam int unsigned CNT_W            = 32;
  // header word indices (byte offset / 4)
  localparam logic [31:0] IDX_HDR_VERSION  = 32'h0000_0000;
  localparam logic [31:0] IDX_UPD_REVISION = 32'h0000_0001;
  localparam logic [31:0] IDX_DATE         = 32'h0000_0002;
  localparam logic [31:0] IDX_PROC_SIG     = 32'h0000_0003;
  localparam logic [31:0] IDX_CHECKSUM     = 32'h0000_0004;
  localparam logic [31:0] IDX_LOADER_REV   = 32'h0000_0005;
  localparam logic [31:0] IDX_PLAT_FLAGS   = 32'h0000_0006;
  localparam logic [31:0] IDX_DATA_SIZE    = 32'h0000_0007;
  localparam logic [31:0] IDX_TOTAL_SIZE   = 32'h0000_0008;
  localparam logic [31:0] HDR_BYTES        = 32'h0000_0030;
  localparam logic [31:0] DEFAULT_DATA     = 32'h0000_07d0;
  localparam logic [31:0] EXT_HDR_BYTES    = 32'h0000_0014;
  localparam logic [31:0] EXT_ENTRY_BYTES  = 32'h0000_000c;
  localparam logic [31:0] SIG_IN_ENTRY     = 32'h0000_0000;
  localparam logic [31:0] FLAGS_IN_ENTRY   = 32'h0000_0004;
  localparam logic [31:0] FIRST_LOADER_REV = 32'h0000_0001;
  localparam int unsigned PLAT_BITS        = 8;
  // avalon register byte addresses
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_PROC_SIG     = 8'h08;
  localparam logic [7:0]  REG_PLAT_ID      = 8'h0c;
  localparam logic [7:0]  REG_LOADER_VER   = 8'h10;
  localparam logic [7:0]  REG_HDR_VERSION  = 8'h14;
  localparam logic [7:0]  REG_UPD_REVISION = 8'h18;
  localparam logic [7:0]  REG_DATE         = 8'h1c;
  localparam logic [7:0]  REG_IMG_SIG      = 8'h20;
  localparam logic [7:0]  REG_IMG_CHECKSUM = 8'h24;
  localparam logic [7:0]  REG_LOADER_REV   = 8'h28;
  localparam logic [7:0]  REG_PLAT_FLAGS   = 8'h2c;
  localparam logic [7:0]  REG_DATA_SIZE    = 8'h30;
  localparam logic [7:0]  REG_TOTAL_SIZE   = 8'h34;
  localparam logic [7:0]  REG_EXT_COUNT    = 8'h38;
  localparam logic [7:0]  REG_NEWER        = 8'h3c;
  // status bit positions
  localparam int unsigned ST_DONE          = 0;
  localparam int unsigned ST_REJECT        = 1;
  localparam int unsigned ST_BUSY          = 2;
  localparam int unsigned ST_C_CSUM        = 8;
  localparam int unsigned ST_C_EXT_CSUM    = 9;
  localparam int unsigned ST_C_SIZE        = 10;
  localparam int unsigned ST_C_SIG         = 11;
  localparam int unsigned ST_C_PLAT        = 12;
  localparam int unsigned ST_C_LOADER      = 13;
  localparam int unsigned CTRL_START       = 0;
  localparam logic [31:0] RESET_ZERO       = 32'h0000_0000;
  typedef enum logic [1:0] {
    UHC_IDLE,
    UHC_SCAN,
    UHC_DONE
  } uhc_state_type;
endpackage : uhc_pkg

// [test/uhc_checker_properties.sv]
module uhc_props (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_readdata_out,
  input  wire logic        avs_waitrequest_out,
  input  wire logic [31:0] img_data_in,
  input  wire logic        img_valid_in,
  input  wire logic        img_ready_out,
  input  wire logic        done_out,
  input  wire logic        reject_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic go_w;
  assign go_w = avs_write_in && avs_address_in == 6'h00 && avs_byteenable_in[0]
                && avs_writedata_in[0];
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_take;
    img_valid_in && img_ready_out;
  endsequence
  sequence s_read_held;
    avs_read_in && avs_waitrequest_out ##1 avs_read_in;
  endsequence
  a_write_no_wait: assert property (avs_write_in |-> !avs_waitrequest_out)
    else $error("write was made to wait");
  a_read_waits: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
    else $error("read answered without a wait cycle");
  a_read_answer: assert property (s_read_held |-> !avs_waitrequest_out)
    else $error("read not answered in its second cycle");
  a_reject_done: assert property (reject_out |-> done_out)
    else $error("reject without done");
  a_done_no_ready: assert property (done_out |-> !img_ready_out)
    else $error("ready while done");
  a_done_holds: assert property (done_out && !go_w |=> done_out && $stable(reject_out))
    else $error("verdict changed without a start");
  a_start_scan: assert property (go_w && !img_ready_out |=> img_ready_out)
    else $error("start did not open the stream");
  a_scan_stays: assert property (s_take ##1 !done_out |-> img_ready_out)
    else $error("stream closed before the last word");
  a_done_after_take: assert property ($rose(done_out) |-> $past(img_valid_in && img_ready_out))
    else $error("done rose without a word taken");
  a_reset_clear: assert property (disable iff (1'b0)
    reset_in |=> !done_out && !reject_out && !img_ready_out)
    else $error("outputs not cleared by reset");
endmodule : uhc_props

bind uhc_checker uhc_props u_props (.*);

// [test/uhc_loader.sv]
module uhc_loader (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        start_in,
  input  wire logic        slow_in,
  input  wire logic [9:0]  len_in,
  input  wire logic        ready_in,
  output logic      [31:0] data_out,
  output logic             valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:1023];
  logic [9:0]  idx;
  logic        busy;
  // released bus shows inverted data so a stale word never matches
  assign data_out = valid_out ? mem[idx] : ~mem[idx];
  always_ff @(posedge clk_in) begin
    if (reset_in || start_in) begin
      idx       <= '0;
      busy      <= start_in;
      valid_out <= start_in;
    end else if (valid_out && ready_in) begin
      idx       <= idx + 10'h001;
      busy      <= (idx + 10'h001) != len_in;
      valid_out <= !slow_in && ((idx + 10'h001) != len_in);
    end else begin
      valid_out <= busy;
    end
  end
endmodule : uhc_loader

// [test/update_image_header_checker_tb_top.sv]
module update_image_header_checker_tb_top;
  import uhc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PSIG = 32'h0000_0a21; // arbitrary value
  logic core_clk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [5:0] avs_address_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, img_data_in;
  logic img_valid_in, img_ready_out, done_out, reject_out, ld_start, ld_slow;
  logic [9:0] ld_len;
  int errors, n_tests;
  int cyc = 0;
  uhc_checker u_dut (.*);
  uhc_loader u_ldr (.clk_in(core_clk_in), .reset_in(reset_in), .start_in(ld_start),
    .slow_in(ld_slow), .len_in(ld_len), .ready_in(img_ready_out), .data_out(img_data_in),
    .valid_out(img_valid_in));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address_in <= a[7:2];
    avs_writedata_in <= d;
    avs_write_in <= 1'b1;
    do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    avs_address_in <= a[7:2];
    avs_read_in <= 1'b1;
    do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
    @(posedge core_clk_in);
    chk(d, e);
  endtask : rc
  task automatic img(input logic [31:0] ds, input int n, input logic [31:0] sg, fl, rv, ld,
                     input logic [31:0] es, input int bad);
    int pw, e, tw;
    logic [31:0] s;
    pw = (ds == 32'h0) ? 500 : int'((ds + 32'h3) / 32'h4);
    e = 12 + pw;
    tw = e + ((n > 0) ? 5 + 3 * n : 0);
    for (int i = 9; i < tw; i++) u_ldr.mem[i] = 32'h5a00_0000 + 32'(i);
    u_ldr.mem[0] = 32'h0000_0001;
    u_ldr.mem[1] = rv;
    u_ldr.mem[2] = 32'h0315_2004;
    u_ldr.mem[3] = sg;
    u_ldr.mem[4] = 32'h0;
    u_ldr.mem[5] = ld;
    u_ldr.mem[6] = fl;
    u_ldr.mem[7] = ds;
    u_ldr.mem[8] = (ds == 32'h0) ? 32'h0000_0800 : 32'(4 * tw);
    if (n > 0) begin
      u_ldr.mem[e] = 32'(n);
      u_ldr.mem[e + 1] = 32'h0;
      for (int k = 0; k < n; k++) begin
        u_ldr.mem[e + 5 + 3 * k] = es ^ 32'(k);
        u_ldr.mem[e + 6 + 3 * k] = fl;
      end
      s = 32'h0;
      for (int i = e; i < tw; i++) s += u_ldr.mem[i];
      u_ldr.mem[e + 1] = -s;
    end
    // shifts one unit between tables: whole image still sums to zero
    if (bad == 2) begin
      u_ldr.mem[e + 2] += 32'h1;
      u_ldr.mem[12] -= 32'h1;
    end
    s = 32'h0;
    for (int i = 0; i < tw; i++) s += u_ldr.mem[i];
    u_ldr.mem[4] = -s;
    if (bad == 1) u_ldr.mem[13] ^= 32'h10;
    ld_len <= 10'(tw);
  endtask : img
  task automatic go(input logic slow, input logic [31:0] exp, input logic [31:0] msk);
    ld_slow <= slow;
    wr(REG_CTRL, 32'h1);
    ld_start <= 1'b1;
    @(posedge core_clk_in);
    ld_start <= 1'b0;
    while (done_out !== 1'b1) @(posedge core_clk_in);
    chk(32'(reject_out), 32'(exp[ST_REJECT]));
    rc(REG_STATUS, exp & msk);
  endtask : go
  task automatic t_regs;
    rc(REG_STATUS, 32'h0);
    rc(REG_LOADER_VER, FIRST_LOADER_REV);
    wr(8'h40, 32'hffff_ffff);
    rc(8'h40, 32'h0);
    wr(REG_PROC_SIG, PSIG);
    wr(REG_PLAT_ID, 32'h04);
    rc(REG_PROC_SIG, PSIG);
    rc(REG_PLAT_ID, 32'h04);
  endtask : t_regs
  task automatic t_good;
    img(32'h10, 0, PSIG, 32'h86, 32'h5, 32'h1, 32'h0, 0);
    go(1'b0, 32'h1, 32'h3f07);
    rc(REG_HDR_VERSION, 32'h1);
    rc(REG_DATE, 32'h0315_2004);
    rc(REG_PLAT_FLAGS, 32'h86);
    rc(REG_TOTAL_SIZE, 32'h40);
    rc(REG_NEWER, 32'h5);
    rc(REG_IMG_SIG, PSIG);
    rc(REG_LOADER_REV, 32'h1);
    rc(REG_DATA_SIZE, 32'h10);
    rc(REG_IMG_CHECKSUM, u_ldr.mem[4]);
  endtask : t_good
  task automatic t_rev;
    img(32'h10, 0, PSIG, 32'h04, 32'hffff_fff0, 32'h1, 32'h0, 0);
    go(1'b0, 32'h1, 32'h3f07);
    rc(REG_UPD_REVISION, 32'hffff_fff0);
    rc(REG_NEWER, 32'h5);
  endtask : t_rev
  task automatic t_ext;
    img(32'h8, 2, PSIG ^ 32'h100, 32'h04, 32'h6, 32'h1, PSIG ^ 32'h1, 0);
    go(1'b0, 32'h1, 32'h3f07);
    rc(REG_EXT_COUNT, 32'h2);
  endtask : t_ext
  task automatic t_faults;
    img(32'h10, 0, PSIG, 32'h04, 32'h7, 32'h1, 32'h0, 1);
    go(1'b0, 32'h103, 32'h3f03);
    rc(REG_NEWER, 32'h6);
    img(32'h8, 1, PSIG, 32'h04, 32'h7, 32'h1, PSIG, 2);
    go(1'b0, 32'h203, 32'h3f03);
    img(32'h10, 0, PSIG ^ 32'h1, 32'h04, 32'h7, 32'h1, 32'h0, 0);
    go(1'b0, 32'h803, 32'h3f03);
    img(32'h10, 0, PSIG, 32'h03, 32'h7, 32'h1, 32'h0, 0);
    go(1'b0, 32'h1003, 32'h3f03);
    img(32'h10, 0, PSIG, 32'h04, 32'h7, 32'h0, 32'h0, 0);
    go(1'b0, 32'h2003, 32'h3f03);
    img(32'h10, 0, PSIG, 32'h04, 32'h7, 32'h2, 32'h0, 0);
    go(1'b0, 32'h2003, 32'h3f03);
    img(32'h6, 0, PSIG, 32'h04, 32'h7, 32'h1, 32'h0, 0);
    go(1'b0, 32'h403, 32'h403);
  endtask : t_faults
  task automatic t_big;
    img(32'h0, 0, PSIG, 32'h04, 32'h8, 32'h1, 32'h0, 0);
    go(1'b1, 32'h1, 32'h3f07);
    rc(REG_NEWER, 32'h8);
  endtask : t_big
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    // whole plan needs under two thousand cycles
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    {reset_in, avs_read_in, avs_write_in, ld_start, ld_slow} = 5'h10;
    {avs_address_in, avs_writedata_in, ld_len} = '0;
    avs_byteenable_in = 4'hf;
    errors = 0;
    n_tests = 0;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    t_regs;
    t_good;
    t_rev;
    t_ext;
    t_faults;
    t_big;
    end_of_test;
  end
endmodule : update_image_header_checker_tb_top
